// >>> ipm_ctrl.sv
`timescale 1ns/1ps
// How it works
// R1: latch flags at sample phase, poll next cycle
// R2: call vector unless equal/higher level active
// R3: call only on instruction's final cycle
// R4: no call during return_from_interrupt or priority/enable access
// R5: denied requests are not remembered
// R6: push pc, not status word, load vector
// R7: fixed vector address per source
// R8: return_from_interrupt clears active level in-progress state
// R9: plain return keeps in-progress state set
// R10: main priority register bits five to zero
// R11: extra priority register bits four, one, zero
// R12: idle bit halts cpu, peripherals run
// R13: idle preserves all cpu state
// R14: enabled interrupt clears idle, gets serviced
// R15: external reset held two machine cycles
// R16: internal reset restarts after three cycles
// R17: power-down halts clock, disables peripherals
// R18: only reset leaves power-down
// R19: power control at 87, reset 00, fields
// R20: bits three, two are uart2 clock flags
// R21: high preempts low, high never preempted
// R22: fixed polling order within a level
// R23: idle plus power-down written gives power-down
module ipm_ctrl #(
  parameter int P_NSRC    = ipm_pkg::N_SRC,
  parameter int P_RESTART = ipm_pkg::RESTART_CYCLES
) (
  input  wire logic                      i_ref_clk,
  input  wire logic                      i_resetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [ipm_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output logic [31:0]                    prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic [P_NSRC-1:0]         i_req,
  input  wire logic                      i_sample_phase,
  input  wire logic                      i_cycle_end,
  input  wire logic                      i_last_cycle,
  input  wire logic                      i_instr_return_from_interrupt,
  input  wire logic                      i_instr_ret,
  input  wire logic                      i_prio_en_access,
  input  wire logic                      i_int_reset,
  input  wire logic [15:0]               i_pc,
  output logic                           o_call,
  output logic [15:0]                    o_vector,
  output logic [15:0]                    o_push_pc,
  output logic                           o_save_psw,
  output logic [1:0]                     o_in_progress,
  output logic                           o_cpu_halt,
  output logic                           o_clk_halt,
  output logic                           o_periph_off,
  output logic                           o_core_hold,
  output ipm_pkg::ipm_pwr_ctrl_s          o_pwr_ctrl
);
  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (P_NSRC != ipm_pkg::N_SRC) begin : g_bad_nsrc
    $error("source count must match vector table");
  end
  if (P_RESTART < 1 || P_RESTART > 7) begin : g_bad_rst
    $error("restart count out of range");
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  ipm_pkg::ipm_pwr_ctrl_s  pwr_ff;
  logic [7:0]              prio_main_ff;
  logic [7:0]              prio_ext_ff;
  logic [31:0]             rdata_ff;
  logic [P_NSRC-1:0]       sample_ff;
  logic [P_NSRC-1:0]       poll_ff;
  logic [1:0]              inprog_ff;
  logic                    call_ff;
  logic [15:0]             vector_ff;
  logic [15:0]             push_pc_ff;
  logic [2:0]              hold_cnt_ff;
  ipm_pkg::ipm_grant_s     grant;
  logic [P_NSRC-1:0]       prio_vec;
  logic [7:0]              idx;
  logic                    mapped;
  logic                    wr_en;
  logic                    boundary;
  logic                    take;
  logic [7:0]              wbyte;
  ipm_pkg::ipm_pwr_ctrl_s  nxt_pwr;

  assign idx    = paddr[9:2];
  assign mapped = (paddr[ipm_pkg::ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00) &&
                  (idx == ipm_pkg::PWR_CTRL_IDX || idx == ipm_pkg::PRIO_EXT_IDX ||
                   idx == ipm_pkg::PRIO_MAIN_IDX);
  assign wr_en  = psel && penable && pwrite && mapped;
  assign wbyte  = pwdata[7:0];

  // ---------------------------------------------------------------
  // apb slave: zero wait states, read data fetched in setup
  // ---------------------------------------------------------------
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = rdata_ff;

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      rdata_ff <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdata_ff <= 32'h0000_0000;
      if (mapped && idx == ipm_pkg::PWR_CTRL_IDX) begin
        rdata_ff[7:0] <= pwr_ff;
      end
      if (mapped && idx == ipm_pkg::PRIO_MAIN_IDX) begin
        rdata_ff[7:0] <= prio_main_ff & ipm_pkg::PRIO_MAIN_MSK;
      end
      if (mapped && idx == ipm_pkg::PRIO_EXT_IDX) begin
        rdata_ff[7:0] <= prio_ext_ff & ipm_pkg::PRIO_EXT_MSK;
      end
    end
  end

  // ---------------------------------------------------------------
  // priority registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      prio_main_ff <= ipm_pkg::PRIO_RST;
      prio_ext_ff  <= ipm_pkg::PRIO_RST;
    end else if (wr_en) begin
      if (idx == ipm_pkg::PRIO_MAIN_IDX) begin
        prio_main_ff <= wbyte & ipm_pkg::PRIO_MAIN_MSK; // R10
      end
      if (idx == ipm_pkg::PRIO_EXT_IDX) begin
        prio_ext_ff <= wbyte & ipm_pkg::PRIO_EXT_MSK; // R11
      end
    end
  end

  // ---------------------------------------------------------------
  // power control
  // ---------------------------------------------------------------
  always_comb begin
    nxt_pwr = pwr_ff;
    if (take || i_int_reset) begin
      nxt_pwr.sleep_request = 1'b0; // R14
    end
    if (i_int_reset) begin
      nxt_pwr.power_down_request = 1'b0; // R18
    end
    // a software write wins over the hardware idle clear
    if (wr_en && idx == ipm_pkg::PWR_CTRL_IDX) begin
      nxt_pwr = ipm_pkg::ipm_pwr_ctrl_s'(wbyte); // R19 R20
      // once down only reset releases the bit
      // an internal reset in the same cycle still releases power-down unless the written byte sets the bit
      nxt_pwr.power_down_request = wbyte[ipm_pkg::PC_PD] |
                                   (pwr_ff.power_down_request & !i_int_reset); // R18
      if (wbyte[ipm_pkg::PC_PD]) begin
        nxt_pwr.sleep_request = 1'b0; // R23
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      pwr_ff <= ipm_pkg::ipm_pwr_ctrl_s'(ipm_pkg::PWR_CTRL_RST); // R19
    end else begin
      pwr_ff <= nxt_pwr;
    end
  end

  // halting the cpu leaves its state untouched; nothing here resets it
  assign o_cpu_halt   = pwr_ff.sleep_request | pwr_ff.power_down_request; // R12 R13
  assign o_clk_halt   = pwr_ff.power_down_request; // R17
  assign o_periph_off = pwr_ff.power_down_request; // R17
  assign o_pwr_ctrl   = pwr_ff;

  // ---------------------------------------------------------------
  // restart delay after internal reset
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      hold_cnt_ff <= 3'h0;
    end else if (i_int_reset) begin
      hold_cnt_ff <= 3'(P_RESTART); // R16
    end else if (i_cycle_end && hold_cnt_ff != 3'h0) begin
      hold_cnt_ff <= hold_cnt_ff - 3'h1;
    end
  end
  assign o_core_hold = (hold_cnt_ff != 3'h0);

  // ---------------------------------------------------------------
  // flag sampling and polling
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      sample_ff <= '0;
      poll_ff   <= '0;
    end else begin
      if (i_sample_phase) begin
        sample_ff <= i_req; // R1
      end
      // poll_ff is rebuilt every cycle, so a denial leaves no trace
      if (i_cycle_end) begin
        poll_ff <= sample_ff; // R1 R5
      end
    end
  end

  // priority bit per source from the two registers
  for (genvar g = 0; g < P_NSRC; g++) begin : g_prio
    assign prio_vec[g] = ipm_pkg::PRIO_IN_EXT[g] ?
                         prio_ext_ff[ipm_pkg::PRIO_POS[g]] :
                         prio_main_ff[ipm_pkg::PRIO_POS[g]];
  end

  // high level first, then polling order inside the level
  always_comb begin
    grant = '0;
    for (int i = P_NSRC - 1; i >= 0; i--) begin
      if (poll_ff[i] && !prio_vec[i] && inprog_ff == 2'b00) begin
        grant.valid = 1'b1; // R22
        grant.level = 1'b0;
        grant.src   = ipm_pkg::SRC_W'(i);
      end
    end
    for (int i = P_NSRC - 1; i >= 0; i--) begin
      if (poll_ff[i] && prio_vec[i] && !inprog_ff[ipm_pkg::LVL_HI]) begin
        grant.valid = 1'b1; // R2 R21
        grant.level = 1'b1;
        grant.src   = ipm_pkg::SRC_W'(i);
      end
    end
  end

  // a halted cpu sits on an instruction boundary
  assign boundary = i_last_cycle || pwr_ff.sleep_request; // R3
  assign take = i_cycle_end && boundary && grant.valid && !i_instr_return_from_interrupt &&
                !i_prio_en_access && !pwr_ff.power_down_request &&
                !o_core_hold && !i_int_reset; // R4 R16 R18

  // ---------------------------------------------------------------
  // vector call and in-progress tracking
  // ---------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      call_ff    <= 1'b0;
      vector_ff  <= 16'h0000;
      push_pc_ff <= 16'h0000;
    end else begin
      call_ff <= take;
      if (take) begin
        vector_ff  <= ipm_pkg::VECTOR[grant.src]; // R7
        push_pc_ff <= i_pc; // R6
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn || i_int_reset) begin
      inprog_ff <= 2'b00;
    end else if (take) begin
      inprog_ff[grant.level] <= 1'b1;
    end else if (i_cycle_end && i_instr_return_from_interrupt) begin
      // plain return (i_instr_ret) deliberately leaves this alone: R9
      if (inprog_ff[ipm_pkg::LVL_HI]) begin
        inprog_ff[ipm_pkg::LVL_HI] <= 1'b0; // R8
      end else begin
        inprog_ff[ipm_pkg::LVL_LO] <= 1'b0; // R8
      end
    end
  end

  assign o_call        = call_ff;
  assign o_vector      = vector_ff;
  assign o_push_pc     = push_pc_ff;
  assign o_save_psw    = 1'b0; // R6
  assign o_in_progress = inprog_ff;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);

  property p_sample;
    i_sample_phase |=> sample_ff == $past(i_req);
  endproperty
  a_sample: assert property (p_sample) else $error("flags not sampled"); // R1

  property p_poll;
    i_cycle_end |=> poll_ff == $past(sample_ff);
  endproperty
  a_poll: assert property (p_poll) else $error("poll not from sample"); // R1

  property p_boundary;
    o_call |-> $past(i_last_cycle || pwr_ff.sleep_request) && $past(i_cycle_end);
  endproperty
  a_boundary: assert property (p_boundary) else $error("call mid instruction"); // R3

  property p_block;
    $past(i_instr_return_from_interrupt || i_prio_en_access) |-> !o_call;
  endproperty
  a_block: assert property (p_block) else $error("call not blocked"); // R4

  property p_hi_busy;
    $past(inprog_ff[1]) && !$past(i_int_reset) |-> !o_call;
  endproperty
  a_hi_busy: assert property (p_hi_busy) else $error("high routine preempted"); // R21

  property p_push;
    o_call |-> o_push_pc == $past(i_pc) && !o_save_psw;
  endproperty
  a_push: assert property (p_push) else $error("wrong pc pushed"); // R6

  property p_vec_ext0;
    o_call && $past(poll_ff[0] && prio_vec[0]) |-> o_vector == 16'h0003;
  endproperty
  a_vec_ext0: assert property (p_vec_ext0) else $error("wrong ext0 vector"); // R7 R22

  property p_return_from_interrupt;
    i_cycle_end && i_instr_return_from_interrupt && inprog_ff == 2'b11 && !i_int_reset
      |=> inprog_ff == 2'b01;
  endproperty
  a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return_from_interrupt level not cleared"); // R8

  property p_ret;
    i_cycle_end && i_instr_ret && !i_instr_return_from_interrupt && !take && !i_int_reset
      |=> inprog_ff == $past(inprog_ff);
  endproperty
  a_ret: assert property (p_ret) else $error("plain return changed state"); // R9

  property p_pd_stays;
    pwr_ff.power_down_request && !i_int_reset |=> pwr_ff.power_down_request;
  endproperty
  a_pd_stays: assert property (p_pd_stays) else $error("left power-down"); // R18

  property p_both;
    wr_en && idx == ipm_pkg::PWR_CTRL_IDX && wbyte[1:0] == 2'b11
      |=> o_clk_halt && !pwr_ff.sleep_request;
  endproperty
  a_both: assert property (p_both) else $error("idle beat power-down"); // R23

  property p_wake;
    take && pwr_ff.sleep_request && !wr_en |=> !pwr_ff.sleep_request ##0 o_call;
  endproperty
  a_wake: assert property (p_wake) else $error("idle not ended"); // R14

  c_call_hi:  cover property (o_call && inprog_ff == 2'b11);
  c_wake:     cover property (pwr_ff.sleep_request ##1 o_call);
  c_pd:       cover property ($rose(o_clk_halt));
  c_restart:  cover property ($fell(o_core_hold));
endmodule : ipm_ctrl

// >>> ipm_pkg.sv
package ipm_pkg;
  // ---------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0]  PWR_CTRL_IDX  = 8'h87;
  localparam logic [7:0]  PRIO_EXT_IDX  = 8'hB7;
  localparam logic [7:0]  PRIO_MAIN_IDX = 8'hB8;
  localparam int          ADDR_W        = 12;
  localparam logic [7:0]  PWR_CTRL_RST  = 8'h00;
  localparam logic [7:0]  PRIO_RST      = 8'h00;
  localparam logic [7:0]  PRIO_MAIN_MSK = 8'h3F;
  localparam logic [7:0]  PRIO_EXT_MSK  = 8'h13;
  // power control fields
  localparam int PC_IDLE = 0;
  localparam int PC_PD   = 1;
  // ---------------------------------------------------------------
  // sources in polling order, highest first
  // ---------------------------------------------------------------
  localparam int N_SRC = 9;
  localparam int SRC_W = 4;
  // priority bit position of each source, with its register
  localparam int         PRIO_POS [N_SRC] = '{0, 4, 1, 1, 2, 3, 0, 4, 5};
  localparam logic [8:0] PRIO_IN_EXT      = 9'h04A;
  localparam logic [15:0] VECTOR [N_SRC] = '{16'h0003, 16'h004B, 16'h000B,
                                            16'h0043, 16'h0013, 16'h001B,
                                            16'h0033, 16'h0023, 16'h002B};
  localparam int RESTART_CYCLES = 3;
  localparam int LVL_LO = 0;
  localparam int LVL_HI = 1;

  typedef struct packed {
    logic uart_baud_doubler;
    logic second_uart_baud_doubler;
    logic low_voltage_reset_disable;
    logic adc_interrupt_enable;
    logic uart2_receive_clock_sel;
    logic uart2_transmit_clock_sel;
    logic power_down_request;
    logic sleep_request;
  } ipm_pwr_ctrl_s;

  typedef struct packed {
    logic            valid;
    logic            level;
    logic [SRC_W-1:0] src;
  } ipm_grant_s;
endpackage : ipm_pkg

// >>> ipm_core_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------
// core sequencer model: four clocks to a machine cycle
// ---------------------------------------------------------------
// flags are sampled late (clock 2), the cycle ends on clock 3; the pc
// moves each machine cycle so a stale push value shows up
module ipm_core_model (
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  output logic             o_sample_phase,
  output logic             o_cycle_end,
  output logic [15:0]      o_pc
);
  logic [1:0] phase_ff;
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      phase_ff <= 2'h0;
      o_pc     <= 16'h1200;
    end else begin
      phase_ff <= phase_ff + 2'h1;
      if (phase_ff == 2'h3) o_pc <= o_pc + 16'h0001;
    end
  end
  assign o_sample_phase = i_resetn && (phase_ff == 2'h2);
  assign o_cycle_end    = i_resetn && (phase_ff == 2'h3);
endmodule : ipm_core_model

// >>> tb_ipm_ctrl.sv
`timescale 1ns/1ps
module tb_ipm_ctrl;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, sph, cend, call, processor_status_word, chalt, khalt, poff, hold;
  logic [8:0]  req = 9'h000;
  logic last = 1'b1, return_from_interrupt = 1'b0, ret = 1'b0, acc = 1'b0, ireset = 1'b0;
  logic [15:0] pc, vec, push;
  logic [1:0]  inprog;
  ipm_pkg::ipm_pwr_ctrl_s pwr;
  int err_total = 0, num_checks = 0, n;
  logic [15:0] vt [9] = '{16'h0003, 16'h004B, 16'h000B, 16'h0043, 16'h0013,
                          16'h001B, 16'h0033, 16'h0023, 16'h002B};
  localparam logic [11:0] A_PWR = 12'h21C, A_MAIN = 12'h2E0, A_EXT = 12'h2DC;

  initial forever #2 clk = ~clk;
  ipm_core_model ipm_core_model_i (.i_ref_clk(clk), .i_resetn(resetn),
    .o_sample_phase(sph), .o_cycle_end(cend), .o_pc(pc));
  ipm_ctrl ipm_ctrl_i (.i_ref_clk(clk), .i_resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .i_req(req),
    .i_sample_phase(sph), .i_cycle_end(cend), .i_last_cycle(last),
    .i_instr_return_from_interrupt(return_from_interrupt), .i_instr_ret(ret), .i_prio_en_access(acc),
    .i_int_reset(ireset), .i_pc(pc), .o_call(call), .o_vector(vec),
    .o_push_pc(push), .o_save_psw(processor_status_word), .o_in_progress(inprog),
    .o_cpu_halt(chalt), .o_clk_halt(khalt), .o_periph_off(poff),
    .o_core_hold(hold), .o_pwr_ctrl(pwr));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
    // let the written value settle before anyone looks at it
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("read data", x, r);
    chk("slave error", {31'h0, xe}, {31'h0, e});
  endtask : rd

  // request stays up until a call or the span ends, then is dropped
  task automatic wait_call(input logic xc, input logic [15:0] xv);
    logic got;
    got = 1'b0;
    for (int i = 0; i < 24 && !got; i++) begin
      @(posedge clk);
      got = (call === 1'b1);
    end
    req <= 9'h000;
    chk("call", {31'h0, xc}, {31'h0, got});
    if (xc && got) begin
      chk("vector", {16'h0, xv}, {16'h0, vec});
      chk("pushed pc", {16'h0, pc - 16'h0001}, {16'h0, push});
      chk("status saved", 32'h0, {31'h0, processor_status_word});
    end
  endtask : wait_call

  // holds one instruction kind over one whole machine cycle
  task automatic instr(input int k);
    do @(posedge clk); while (cend !== 1'b1);
    if (k == 0) return_from_interrupt <= 1'b1; else ret <= 1'b1;
    do @(posedge clk); while (cend !== 1'b1);
    return_from_interrupt <= 1'b0; ret <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : instr

  task automatic prog(input logic [1:0] x);
    chk("in progress", {30'h0, x}, {30'h0, inprog});
  endtask : prog

  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  initial begin
    #100000;
    err_total++;
    results();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(A_PWR, 32'h0, 1'b0);
    rd(A_MAIN, 32'h0, 1'b0);
    wr(A_MAIN, 8'hFF);
    rd(A_MAIN, 32'h3F, 1'b0);
    wr(A_EXT, 8'hFF);
    rd(A_EXT, 32'h13, 1'b0);
    rd(12'h004, 32'h0, 1'b1);
    wr(A_MAIN, 8'h00);
    wr(A_EXT, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 9; i++) begin
      req <= 9'h001 << i;
      wait_call(1'b1, vt[i]);
      prog(2'h1);
      instr(0);
      prog(2'h0);
    end
    $display("test vectors done");
    req <= 9'h1FF;
    wait_call(1'b1, 16'h0003);
    instr(0);
    wr(A_MAIN, 8'h20);
    req <= 9'h1FF;
    wait_call(1'b1, 16'h002B);
    prog(2'h2);
    req <= 9'h001;
    wait_call(1'b0, 16'h0);
    instr(0);
    req <= 9'h001;
    wait_call(1'b1, 16'h0003);
    req <= 9'h100;
    wait_call(1'b1, 16'h002B);
    prog(2'h3);
    instr(0);
    prog(2'h1);
    instr(0);
    wr(A_MAIN, 8'h21);
    req <= 9'h1FF;
    wait_call(1'b1, 16'h0003);
    prog(2'h2);
    instr(0);
    wr(A_MAIN, 8'h00);
    $display("test priority done");
    last <= 1'b0;
    req <= 9'h004;
    wait_call(1'b0, 16'h0);
    last <= 1'b1;
    acc <= 1'b1;
    req <= 9'h004;
    wait_call(1'b0, 16'h0);
    // keep blocking until the stale sample has left the poll stage
    repeat (8) @(posedge clk);
    acc <= 1'b0;
    wait_call(1'b0, 16'h0);
    req <= 9'h001;
    wait_call(1'b1, 16'h0003);
    instr(1);
    prog(2'h1);
    req <= 9'h010;
    wait_call(1'b0, 16'h0);
    instr(0);
    prog(2'h0);
    $display("test blocking done");
    wr(A_PWR, 8'h01);
    chk("cpu halt", 32'h1, {31'h0, chalt});
    chk("clock halt", 32'h0, {31'h0, khalt});
    last <= 1'b0;
    req <= 9'h004;
    wait_call(1'b1, 16'h000B);
    rd(A_PWR, 32'h0, 1'b0);
    last <= 1'b1;
    instr(0);
    wr(A_PWR, 8'h03);
    rd(A_PWR, 32'h02, 1'b0);
    chk("clock halt", 32'h1, {31'h0, khalt});
    chk("periph off", 32'h1, {31'h0, poff});
    req <= 9'h001;
    wait_call(1'b0, 16'h0);
    wr(A_PWR, 8'h00);
    rd(A_PWR, 32'h02, 1'b0);
    @(posedge clk);
    ireset <= 1'b1;
    @(posedge clk);
    ireset <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge clk);
      if (hold === 1'b1 && cend === 1'b1) n++;
    end
    chk("hold cycles", 32'd3, n);
    rd(A_PWR, 32'h0, 1'b0);
    $display("test power done");
    wr(A_PWR, 8'hFC);
    rd(A_PWR, 32'hFC, 1'b0);
    chk("power fields", 32'hFC, {24'h0, pwr});
    $display("test fields done");
    wr(A_MAIN, 8'h3F);
    wr(A_PWR, 8'h01);
    resetn <= 1'b0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    rd(A_PWR, 32'h0, 1'b0);
    chk("cpu halt", 32'h0, {31'h0, chalt});
    rd(A_MAIN, 32'h0, 1'b0);
    $display("test reset done");
    results();
  end
endmodule : tb_ipm_ctrl
